// ---- slscs_host.sv ----
`timescale 1ns/1ns
// ********
// Two-wire bus host model
// ********
module slscs_host (
  // Clock.
  input wire i_clk,
  // Wire level of the data line.
  input wire i_sda,
  // Serial clock level and data pull-down.
  output reg o_scl,
  output reg o_sda_low
);
  // Both lines rest released; the clock only moves inside frames.
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // A third of a serial bit, the clock's high time, kept above the slave's minimum of four clocks.
  task automatic hp;
    repeat (5) @(posedge i_clk);
  endtask
  // Data moves only while the clock is low, so no false start or stop is seen.
  task automatic bit_io(input b, output s);
    o_sda_low <= !b;
    hp;
    o_scl <= 1'b1;
    hp;
    s = i_sda;
    o_scl <= 1'b0;
    hp;
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start;
    o_sda_low <= 1'b0;
    hp;
    o_scl <= 1'b1;
    hp;
    o_sda_low <= 1'b1;
    hp;
    o_scl <= 1'b0;
    hp;
  endtask
  // Stop: data rises while the clock is high, then both rest released.
  task automatic stop;
    o_sda_low <= 1'b1;
    hp;
    o_scl <= 1'b1;
    hp;
    o_sda_low <= 1'b0;
    hp;
  endtask
  // Sends a byte most significant bit first and returns the slave's ack.
  task automatic wr_byte(input [7:0] d, output ack);
    integer i;
    reg s;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // Receives a byte, then acks it or ends the read with a not-ack.
  task automatic rd_byte(output [7:0] d, input ack);
    integer i;
    reg s;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!ack, s);
  endtask
endmodule

// ---- slscs_i2c_byte.v ----
`timescale 1ns/1ns
// Bit engine of the two-wire slave: start/stop detect, byte shifting and ack slots.
module slscs_i2c_byte (
  // Clock and reset.
  input wire i_clk,
  input wire i_rst_n,
  // Two-wire pins.
  input wire i_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe_n,
  // Events toward the transaction logic.
  output reg o_start,
  output reg o_stop,
  output reg o_rx_valid,
  output reg [7:0] o_rx_byte,
  output reg o_mack_valid,
  output reg o_mack,
  // Steering from the transaction logic.
  input wire i_ack,
  input wire i_tx,
  input wire [7:0] i_tx_byte
);

  reg scl_q;
  reg sda_q;
  reg [3:0] cnt_q;
  reg [7:0] shift_q;
  reg tx_q;
  reg drive_q;
  reg active_q;
  wire start_w;
  wire stop_w;
  wire rise_w;
  wire fall_w;

  // Open drain: the line is only ever pulled low, never driven high.
  assign o_sda = 1'b0;
  assign o_sda_oe_n = ~drive_q;

  // Edges are found against the previous sample of each line.
  assign start_w = i_scl & scl_q & sda_q & ~i_sda;
  assign stop_w = i_scl & scl_q & ~sda_q & i_sda;
  assign rise_w = i_scl & ~scl_q;
  assign fall_w = ~i_scl & scl_q;

  // Bit counter: 0..7 data bits, 8 the ack bit up to its rise, 9 the ack bit's high phase.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 1'b0;
      drive_q <= 1'b0;
      active_q <= 1'b0;
      o_start <= 1'b0;
      o_stop <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_byte <= 8'h00;
      o_mack_valid <= 1'b0;
      o_mack <= 1'b0;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      o_start <= 1'b0;
      o_stop <= 1'b0;
      o_rx_valid <= 1'b0;
      o_mack_valid <= 1'b0;
      if (start_w) begin
        active_q <= 1'b1;
        cnt_q <= 4'h0;
        tx_q <= 1'b0;
        drive_q <= 1'b0;
        o_start <= 1'b1;
      end else if (stop_w) begin
        active_q <= 1'b0;
        cnt_q <= 4'h0;
        tx_q <= 1'b0;
        drive_q <= 1'b0;
        o_stop <= 1'b1;
      end else if (active_q && rise_w) begin
        if (cnt_q < 4'h8) begin
          cnt_q <= cnt_q + 4'h1;
          if (!tx_q) begin
            shift_q <= {shift_q[6:0], i_sda};
          end
          if (!tx_q && cnt_q == 4'h7) begin
            o_rx_valid <= 1'b1;
            o_rx_byte <= {shift_q[6:0], i_sda};
          end
        end else if (cnt_q == 4'h8) begin
          cnt_q <= 4'h9;
          if (tx_q) begin
            o_mack_valid <= 1'b1;
            o_mack <= ~i_sda;
          end
        end
      end else if (active_q && fall_w) begin
        if (cnt_q == 4'h8) begin
          drive_q <= ~tx_q & i_ack;
        end else if (cnt_q == 4'h9) begin
          // A new byte starts here; read bytes go out most significant bit first.
          cnt_q <= 4'h0;
          tx_q <= i_tx;
          shift_q <= i_tx_byte;
          drive_q <= i_tx & ~i_tx_byte[7];
        end else if (tx_q && cnt_q != 4'h0) begin
          shift_q <= {shift_q[6:0], 1'b0};
          drive_q <= ~shift_q[6];
        end
      end
    end
  end

endmodule

// ---- slscs_properties.sv ----
`timescale 1ns/1ns
// Watches the strap latch, decode and pin outputs of the configuration slave.
module slscs_properties (
  // Clock and reset.
  input wire i_clk,
  input wire i_rst_n,
  // Watched inputs.
  input wire i_cpu_power_good_strobe_n,
  input wire i_serial_clock_line,
  // Watched outputs.
  input wire o_sel_valid,
  input wire o_sel_reserved,
  input wire [4:0] o_latched_select,
  input wire [10:0] o_cpu_freq_x10,
  input wire [13:0] o_vco_freq_x10,
  input wire o_powerdown,
  input wire [31:0] o_buf_enable,
  input wire o_serial_data_line_oe_n,
  input wire o_reset_out_or_powerdown_in_pin_oe_n
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ********
  // Sequences
  // ********
  // The strobe is seen low.
  sequence s_strobe_low;
    !i_cpu_power_good_strobe_n;
  endsequence
  // The frozen code has stood for a cycle, so the decode has caught up.
  sequence s_code_settled;
    o_sel_valid && $stable(o_latched_select) && o_latched_select == 5'h1C;
  endsequence

  // ********
  // Properties
  // ********
  a_strobe_sets_valid: assert property (s_strobe_low |-> ##[0:3] o_sel_valid)
    else $error("strobe low did not validate the select latch");
  a_valid_is_sticky: assert property (o_sel_valid |=> o_sel_valid)
    else $error("select valid fell without reset");
  a_latch_stays_frozen: assert property (o_sel_valid |=> $stable(o_latched_select))
    else $error("latched select moved after it was frozen");
  a_decode_code_1c: assert property (s_code_settled |->
    o_cpu_freq_x10 == 11'h3E8 && o_vco_freq_x10 == 14'h1F40)
    else $error("code 1C decoded to wrong frequencies");
  a_reserved_gives_zero: assert property (o_sel_reserved |->
    o_cpu_freq_x10 == 11'h000 && o_vco_freq_x10 == 14'h0000)
    else $error("reserved code left a frequency non-zero");
  a_reset_pin_mode: assert property (!o_reset_out_or_powerdown_in_pin_oe_n |-> !o_powerdown)
    else $error("shared pin driven while in power-down mode");
  a_powerdown_buf_off: assert property (o_powerdown && $past(o_powerdown) |->
    o_buf_enable == 32'h00000000)
    else $error("buffers enabled during power-down");
  a_sda_moves_scl_low: assert property ($changed(o_serial_data_line_oe_n) |->
    !i_serial_clock_line)
    else $error("slave moved the data line while the serial clock was high");
endmodule

// ---- slscs_regs.vh ----
`ifndef SLSCS_REGS_VH
`define SLSCS_REGS_VH

// ****************************************************************
// APB register byte offsets.
// ****************************************************************
`define SLSCS_OFF_STATUS 8'h00
`define SLSCS_OFF_FREQ_A 8'h04
`define SLSCS_OFF_FREQ_B 8'h08
`define SLSCS_OFF_CTRL 8'h0C
`define SLSCS_OFF_BYTE_BASE 8'h10

// ****************************************************************
// Field positions.
// ****************************************************************
`define SLSCS_ST_VALID 0
`define SLSCS_ST_RSVD 1
`define SLSCS_ST_RSTOUT 2
`define SLSCS_ST_PWRDN 3
`define SLSCS_ST_SEL_LSB 8
`define SLSCS_FA_CPU_LSB 0
`define SLSCS_FA_VCO_LSB 16
`define SLSCS_FB_MID_LSB 0
`define SLSCS_FB_PCI_LSB 16
`define SLSCS_CTRL_WDOG 0
`define SLSCS_B0_DRIVE 6

// ****************************************************************
// Serial register file and slave address.
// ****************************************************************
`define SLSCS_NUM_BYTES 7'h06
`define SLSCS_FIRST_OE_BYTE 2
`define SLSCS_SMB_ADDR 8'hD2
`define SLSCS_BYTE0_RST 8'h40
`define SLSCS_BYTE1_RST 8'h7F
`define SLSCS_OE_RST 8'hFF
`define SLSCS_CTRL_RST 1'h0

`endif

// ---- slscs_top.v ----
`timescale 1ns/1ns
`include "slscs_regs.vh"
module slscs_top (
  // Clock and reset.
  input wire i_clk,
  input wire i_rst_n,
  // Straps and power sequencing.
  input wire i_mode_strap,
  input wire [4:0] i_freq_select,
  input wire i_cpu_power_good_strobe_n,
  // Shared reset-out / power-down-in pin.
  input wire i_reset_out_or_powerdown_in_pin,
  output wire o_reset_out_or_powerdown_in_pin,
  output wire o_reset_out_or_powerdown_in_pin_oe_n,
  // Two-wire serial pins.
  input wire i_serial_clock_line,
  input wire i_serial_data_line,
  output wire o_serial_data_line,
  output wire o_serial_data_line_oe_n,
  // APB slave.
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output wire o_pslverr,
  output reg [31:0] o_prdata,
  // Clock generator controls.
  output reg o_powerdown,
  output reg [31:0] o_buf_enable,
  output reg o_sel_valid,
  output reg o_sel_reserved,
  output reg [4:0] o_latched_select,
  output reg [10:0] o_cpu_freq_x10,
  output reg [9:0] o_mid_clock_66mhz_x10,
  output reg [8:0] o_pci_freq_x10,
  output reg [13:0] o_vco_freq_x10
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_COUNT = 3'h3;
  localparam ST_WDATA = 3'h4;
  localparam ST_RDATA = 3'h5;
  localparam ST_IGNORE = 3'h6;
  localparam NB = 6;
  // The address is held as a named constant so its upper seven bits can be selected.
  localparam [7:0] SMB_ADDR = `SLSCS_SMB_ADDR;

  reg mode_cap_reg;
  reg mode_rstout_reg;
  reg sel_valid_reg;
  reg [4:0] sel_reg;
  reg wdog_reg;
  reg [2:0] state_reg;
  reg [6:0] idx_reg;
  reg blk_reg;
  reg cnt_pend_reg;
  reg ack_reg;
  reg single_done_reg;
  reg sm_we_reg;
  reg [6:0] sm_idx_reg;
  reg [7:0] sm_data_reg;
  reg [7:0] tx_byte;
  reg [7:0] rd_byte;
  reg [7:0] apb_byte;
  reg [44:0] dec;
  wire [8*NB-1:0] cfg_flat;
  wire ev_start;
  wire ev_stop;
  wire ev_rx;
  wire [7:0] rx_byte;
  wire ev_mack;
  wire mack;
  wire apb_wr;
  wire apb_setup;
  wire byte_hit;
  wire [7:0] byte_off;
  wire [2:0] apb_idx;
  wire mapped;

  // ****************************************************************
  // Straps.
  // ****************************************************************
  // The mode strap is caught on the first edge after reset release, never by the reset itself.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_cap_reg <= 1'b0;
      mode_rstout_reg <= 1'b1;
    end else if (!mode_cap_reg) begin
      mode_cap_reg <= 1'b1;
      mode_rstout_reg <= i_mode_strap;
    end
  end

  // The select latch is transparent until the strobe is seen low, then frozen for good.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_valid_reg <= 1'b0;
      sel_reg <= 5'h00;
    end else if (!sel_valid_reg) begin
      sel_reg <= i_freq_select;
      sel_valid_reg <= ~i_cpu_power_good_strobe_n;
    end
  end

  // Shared pin: pulled low only as a reset output; otherwise read as power-down.
  assign o_reset_out_or_powerdown_in_pin = 1'b0;
  assign o_reset_out_or_powerdown_in_pin_oe_n = ~(mode_rstout_reg & wdog_reg);

  // ****************************************************************
  // Frequency decode, in tenths of MHz.
  // ****************************************************************
  // Reserved codes decode to zero frequencies and raise the reserved flag.
  always @* begin
    case (sel_reg)
      5'h00: dec = {1'b0, 11'd1007, 10'd671, 9'd336, 14'd8056};
      5'h01: dec = {1'b0, 11'd1002, 10'd668, 9'd334, 14'd8016};
      5'h02: dec = {1'b0, 11'd1080, 10'd720, 9'd360, 14'd8640};
      5'h03: dec = {1'b0, 11'd1012, 10'd675, 9'd337, 14'd8096};
      5'h08: dec = {1'b0, 11'd1257, 10'd629, 9'd314, 14'd7542};
      5'h09: dec = {1'b0, 11'd1303, 10'd651, 9'd326, 14'd7816};
      5'h0A: dec = {1'b0, 11'd1336, 10'd668, 9'd334, 14'd8016};
      5'h0B: dec = {1'b0, 11'd1342, 10'd671, 9'd336, 14'd8052};
      5'h0C: dec = {1'b0, 11'd1345, 10'd673, 9'd336, 14'd8070};
      5'h0D: dec = {1'b0, 11'd1480, 10'd740, 9'd370, 14'd8880};
      5'h12: dec = {1'b0, 11'd1674, 10'd558, 9'd279, 14'd6696};
      5'h13: dec = {1'b0, 11'd1700, 10'd567, 9'd283, 14'd6800};
      5'h14: dec = {1'b0, 11'd1750, 10'd583, 9'd292, 14'd7000};
      5'h15: dec = {1'b0, 11'd1800, 10'd600, 9'd300, 14'd7200};
      5'h16: dec = {1'b0, 11'd1850, 10'd617, 9'd308, 14'd7400};
      5'h17: dec = {1'b0, 11'd1900, 10'd633, 9'd317, 14'd7600};
      5'h18: dec = {1'b0, 11'd1009, 10'd673, 9'd336, 14'd8072};
      5'h19: dec = {1'b0, 11'd1339, 10'd670, 9'd335, 14'd8034};
      5'h1A: dec = {1'b0, 11'd2009, 10'd670, 9'd335, 14'd8036};
      5'h1C: dec = {1'b0, 11'd1000, 10'd667, 9'd333, 14'd8000};
      5'h1D: dec = {1'b0, 11'd1333, 10'd667, 9'd333, 14'd8000};
      5'h1E: dec = {1'b0, 11'd2000, 10'd667, 9'd333, 14'd8000};
      default: dec = {1'b1, 44'h0};
    endcase
  end

  // Decoded values are registered so every clock generator control output leaves a flip-flop.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sel_valid <= 1'b0;
      o_sel_reserved <= 1'b0;
      o_latched_select <= 5'h00;
      o_cpu_freq_x10 <= 11'h000;
      o_mid_clock_66mhz_x10 <= 10'h000;
      o_pci_freq_x10 <= 9'h000;
      o_vco_freq_x10 <= 14'h0000;
      o_powerdown <= 1'b0;
      o_buf_enable <= 32'h00000000;
    end else begin
      o_sel_valid <= sel_valid_reg;
      o_sel_reserved <= dec[44];
      o_latched_select <= sel_reg;
      o_cpu_freq_x10 <= dec[43:33];
      o_mid_clock_66mhz_x10 <= dec[32:23];
      o_pci_freq_x10 <= dec[22:14];
      o_vco_freq_x10 <= dec[13:0];
      o_powerdown <= mode_cap_reg & ~mode_rstout_reg & ~i_reset_out_or_powerdown_in_pin;
      // Power-down stops the buffers but leaves the serial slave running.
      o_buf_enable <= cfg_flat[8*NB-1:8*`SLSCS_FIRST_OE_BYTE] & {32{~o_powerdown}};
    end
  end

  // ****************************************************************
  // Serial register file.
  // ****************************************************************
  assign byte_off = i_paddr - `SLSCS_OFF_BYTE_BASE;
  assign apb_idx = byte_off[4:2];
  assign byte_hit = (i_paddr >= `SLSCS_OFF_BYTE_BASE) && (byte_off[1:0] == 2'h0) &&
                    (byte_off[7:2] < NB);
  assign apb_wr = i_psel & i_penable & i_pwrite;

  // One byte register per entry; serial writes win over an APB write in the same cycle.
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : gen_byte
      reg [7:0] byte_q;
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          byte_q <= (g == 0) ? `SLSCS_BYTE0_RST :
                    (g == 1) ? `SLSCS_BYTE1_RST : `SLSCS_OE_RST;
        end else if (sm_we_reg && sm_idx_reg == g) begin
          byte_q <= sm_data_reg;
        end else if (apb_wr && byte_hit && apb_idx == g) begin
          byte_q <= i_pwdata[7:0];
        end
      end
      assign cfg_flat[8*g+7:8*g] = byte_q;
    end
  endgenerate

  // Byte 0 reads reserved bits as zero and the latched select in its low bits.
  always @* begin
    if (idx_reg == 7'h00) begin
      rd_byte = {2'h0, cfg_flat[`SLSCS_B0_DRIVE], sel_reg} & 8'h5F;
      rd_byte[`SLSCS_B0_DRIVE] = cfg_flat[`SLSCS_B0_DRIVE];
    end else if (idx_reg < `SLSCS_NUM_BYTES) begin
      rd_byte = cfg_flat[8*idx_reg +: 8];
    end else begin
      rd_byte = 8'h00;
    end
    tx_byte = cnt_pend_reg ? {1'b0, `SLSCS_NUM_BYTES} : rd_byte;
  end

  // ****************************************************************
  // Serial transaction sequencer.
  // ****************************************************************
  slscs_i2c_byte u_byte (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_scl(i_serial_clock_line),
    .i_sda(i_serial_data_line),
    .o_sda(o_serial_data_line),
    .o_sda_oe_n(o_serial_data_line_oe_n),
    .o_start(ev_start),
    .o_stop(ev_stop),
    .o_rx_valid(ev_rx),
    .o_rx_byte(rx_byte),
    .o_mack_valid(ev_mack),
    .o_mack(mack),
    .i_ack(ack_reg),
    .i_tx(state_reg == ST_RDATA),
    .i_tx_byte(tx_byte)
  );

  // Every byte event lands here; the bit engine waits out the eighth bit's high phase for the ack decision.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      idx_reg <= 7'h00;
      blk_reg <= 1'b0;
      cnt_pend_reg <= 1'b0;
      ack_reg <= 1'b0;
      single_done_reg <= 1'b0;
      sm_we_reg <= 1'b0;
      sm_idx_reg <= 7'h00;
      sm_data_reg <= 8'h00;
    end else begin
      sm_we_reg <= 1'b0;
      if (ev_start) begin
        state_reg <= ST_ADDR;
        ack_reg <= 1'b0;
      end else if (ev_stop) begin
        state_reg <= ST_IDLE;
        ack_reg <= 1'b0;
      end else if (ev_rx) begin
        case (state_reg)
          ST_ADDR: begin
            if (rx_byte[7:1] == SMB_ADDR[7:1]) begin
              ack_reg <= 1'b1;
              state_reg <= rx_byte[0] ? ST_RDATA : ST_CMD;
              cnt_pend_reg <= rx_byte[0] & blk_reg;
            end else begin
              ack_reg <= 1'b0;
              state_reg <= ST_IGNORE;
            end
          end
          ST_CMD: begin
            ack_reg <= 1'b1;
            blk_reg <= ~rx_byte[7];
            idx_reg <= rx_byte[7] ? rx_byte[6:0] : 7'h00;
            state_reg <= rx_byte[7] ? ST_WDATA : ST_COUNT;
            single_done_reg <= 1'b0;
          end
          ST_COUNT: begin
            ack_reg <= 1'b1;
            state_reg <= ST_WDATA;
          end
          ST_WDATA: begin
            if (idx_reg < `SLSCS_NUM_BYTES && (blk_reg || !single_done_reg)) begin
              ack_reg <= 1'b1;
              sm_we_reg <= 1'b1;
              sm_idx_reg <= idx_reg;
              sm_data_reg <= rx_byte;
              single_done_reg <= 1'b1;
              if (blk_reg) begin
                idx_reg <= idx_reg + 7'h01;
              end
            end else begin
              ack_reg <= 1'b0;
              state_reg <= ST_IGNORE;
            end
          end
          default: begin
            ack_reg <= 1'b0;
          end
        endcase
      end else if (ev_mack && state_reg == ST_RDATA) begin
        // A host not-acknowledge ends the read and releases the data line.
        if (!mack) begin
          state_reg <= ST_IGNORE;
        end else if (cnt_pend_reg) begin
          cnt_pend_reg <= 1'b0;
        end else if (blk_reg) begin
          idx_reg <= idx_reg + 7'h01;
        end
      end
    end
  end

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  assign apb_setup = i_psel & ~i_penable;
  assign mapped = byte_hit || i_paddr == `SLSCS_OFF_STATUS || i_paddr == `SLSCS_OFF_FREQ_A ||
                  i_paddr == `SLSCS_OFF_FREQ_B || i_paddr == `SLSCS_OFF_CTRL;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  // Read data is fetched in the setup cycle so it stands registered through the access.
  always @* begin
    apb_byte = cfg_flat[8*apb_idx +: 8];
    if (apb_idx == 3'h0) begin
      apb_byte = {1'b0, cfg_flat[`SLSCS_B0_DRIVE], 1'b0, sel_reg};
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
      wdog_reg <= `SLSCS_CTRL_RST;
    end else begin
      if (apb_wr && i_paddr == `SLSCS_OFF_CTRL) begin
        wdog_reg <= i_pwdata[`SLSCS_CTRL_WDOG];
      end
      if (apb_setup) begin
        o_prdata <= 32'h00000000;
        if (byte_hit) begin
          o_prdata[7:0] <= apb_byte;
        end else if (i_paddr == `SLSCS_OFF_STATUS) begin
          o_prdata[`SLSCS_ST_VALID] <= sel_valid_reg;
          o_prdata[`SLSCS_ST_RSVD] <= dec[44];
          o_prdata[`SLSCS_ST_RSTOUT] <= mode_rstout_reg;
          o_prdata[`SLSCS_ST_PWRDN] <= o_powerdown;
          o_prdata[`SLSCS_ST_SEL_LSB+4:`SLSCS_ST_SEL_LSB] <= sel_reg;
        end else if (i_paddr == `SLSCS_OFF_FREQ_A) begin
          o_prdata[`SLSCS_FA_CPU_LSB+10:`SLSCS_FA_CPU_LSB] <= dec[43:33];
          o_prdata[`SLSCS_FA_VCO_LSB+13:`SLSCS_FA_VCO_LSB] <= dec[13:0];
        end else if (i_paddr == `SLSCS_OFF_FREQ_B) begin
          o_prdata[`SLSCS_FB_MID_LSB+9:`SLSCS_FB_MID_LSB] <= dec[32:23];
          o_prdata[`SLSCS_FB_PCI_LSB+8:`SLSCS_FB_PCI_LSB] <= dec[22:14];
        end else if (i_paddr == `SLSCS_OFF_CTRL) begin
          o_prdata[`SLSCS_CTRL_WDOG] <= wdog_reg;
        end
      end
    end
  end

endmodule

// ---- slscs_top_test.sv ----
`timescale 1ns/1ns
`include "slscs_regs.vh"
module strap_latch_and_smbus_config_slave_test;
  reg i_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg i_mode_strap = 1'b1;
  reg [4:0] i_freq_select = 5'h1D;
  reg i_cpu_power_good_strobe_n = 1'b1;
  reg i_psel = 1'b0;
  reg i_penable = 1'b0;
  reg i_pwrite = 1'b0;
  reg [7:0] i_paddr = 8'h00;
  reg [31:0] i_pwdata = 32'h00000000;
  reg board_low = 1'b0;
  integer n_mismatch = 0;
  integer checks = 0;
  wire i_serial_clock_line, host_low, o_serial_data_line, o_serial_data_line_oe_n;
  wire o_reset_out_or_powerdown_in_pin, o_reset_out_or_powerdown_in_pin_oe_n;
  wire o_pready, o_pslverr, o_powerdown, o_sel_valid, o_sel_reserved;
  wire [31:0] o_prdata, o_buf_enable;
  wire [4:0] o_latched_select;
  wire [10:0] o_cpu_freq_x10;
  wire [9:0] o_mid_clock_66mhz_x10;
  wire [8:0] o_pci_freq_x10;
  wire [13:0] o_vco_freq_x10;
  // Open-drain lines with pull-ups: low when any party pulls.
  wire i_serial_data_line = !host_low && (o_serial_data_line_oe_n || o_serial_data_line);
  wire i_reset_out_or_powerdown_in_pin = !board_low &&
    (o_reset_out_or_powerdown_in_pin_oe_n || o_reset_out_or_powerdown_in_pin);

  // 50 MHz clock.
  always #10 i_clk = ~i_clk;

  slscs_top i_slscs_top (
    .i_clk, .i_rst_n, .i_mode_strap, .i_freq_select, .i_cpu_power_good_strobe_n,
    .i_reset_out_or_powerdown_in_pin, .o_reset_out_or_powerdown_in_pin,
    .o_reset_out_or_powerdown_in_pin_oe_n, .i_serial_clock_line, .i_serial_data_line,
    .o_serial_data_line, .o_serial_data_line_oe_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_prdata, .o_powerdown, .o_buf_enable,
    .o_sel_valid, .o_sel_reserved, .o_latched_select, .o_cpu_freq_x10,
    .o_mid_clock_66mhz_x10, .o_pci_freq_x10, .o_vco_freq_x10
  );
  slscs_host i_slscs_host (
    .i_clk(i_clk),
    .i_sda(i_serial_data_line),
    .o_scl(i_serial_clock_line),
    .o_sda_low(host_low)
  );

  // ********
  // Tasks
  // ********
  task automatic tally_and_finish;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input [31:0] exp, input [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input exp, input got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input w, input [7:0] a, input [31:0] d, output [31:0] r, output e);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [31:0] exp);
    reg [31:0] r;
    reg e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", exp, r);
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    reg [31:0] r;
    reg e;
    apb(1'b1, a, d, r, e);
    repeat (2) @(posedge i_clk);
  endtask
  // Serial byte out with the ack level expected back.
  task automatic sw(input [7:0] d, input exp_ack);
    reg a;
    i_slscs_host.wr_byte(d, a);
    chk_bit("ack", exp_ack, a);
  endtask
  task automatic sr(input [7:0] exp, input ack);
    reg [7:0] d;
    i_slscs_host.rd_byte(d, ack);
    chk("serial read", {24'h0, exp}, {24'h0, d});
  endtask
  task automatic byte_write(input [6:0] idx, input [7:0] d);
    i_slscs_host.start;
    sw(`SLSCS_SMB_ADDR, 1'b1);
    sw({1'b1, idx}, 1'b1);
    sw(d, 1'b1);
    i_slscs_host.stop;
  endtask
  task automatic byte_read(input [6:0] idx, input [7:0] exp);
    i_slscs_host.start;
    sw(`SLSCS_SMB_ADDR, 1'b1);
    sw({1'b1, idx}, 1'b1);
    i_slscs_host.start;
    sw(8'hD3, 1'b1);
    sr(exp, 1'b0);
    i_slscs_host.stop;
  endtask
  task automatic reset_dut(input mode);
    i_rst_n <= 1'b0;
    i_mode_strap <= mode;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask

  // Cuts a hang short; the tests need well under ten thousand clocks.
  initial begin
    repeat (40000) @(posedge i_clk);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end

  // Main sequence: reset-out mode first, then power-down mode with a reserved code.
  initial begin
    reg [31:0] r;
    reg e;
    reset_dut(1'b1);
    chk_bit("valid", 1'b0, o_sel_valid);
    chk("follow", 32'h1D, {27'h0, o_latched_select});
    i_freq_select <= 5'h1C;
    repeat (3) @(posedge i_clk);
    i_cpu_power_good_strobe_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_freq_select <= 5'h03;
    i_cpu_power_good_strobe_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk("latched", 32'h1C, {27'h0, o_latched_select});
    chk("mid freq", 32'h0000029B, {22'h0, o_mid_clock_66mhz_x10});
    chk("pci freq", 32'h0000014D, {23'h0, o_pci_freq_x10});
    rd(`SLSCS_OFF_STATUS, 32'h00001C05);
    rd(`SLSCS_OFF_FREQ_A, 32'h1F4003E8);
    rd(`SLSCS_OFF_FREQ_B, 32'h014D029B);
    rd(8'h10, 32'h0000005C);
    rd(8'h14, 32'h0000007F);
    apb(1'b0, 8'hFC, 32'h0, r, e);
    chk_bit("pslverr", 1'b1, e);
    wr(`SLSCS_OFF_CTRL, 32'h00000001);
    chk_bit("pin oe_n", 1'b0, o_reset_out_or_powerdown_in_pin_oe_n);
    byte_write(7'h02, 8'h5A);
    chk("buf", 32'hFFFFFF5A, o_buf_enable);
    byte_read(7'h02, 8'h5A);
    // Foreign address: nothing acked, nothing stored.
    i_slscs_host.start;
    sw(8'hD4, 1'b0);
    sw(8'h82, 1'b0);
    i_slscs_host.stop;
    byte_read(7'h02, 8'h5A);
    // Block write announcing six bytes but stopped after two.
    i_slscs_host.start;
    sw(`SLSCS_SMB_ADDR, 1'b1);
    sw(8'h00, 1'b1);
    sw(8'h06, 1'b1);
    sw(8'h11, 1'b1);
    sw(8'h22, 1'b1);
    i_slscs_host.stop;
    // Block read: count, then bytes from index 0 upward.
    i_slscs_host.start;
    sw(`SLSCS_SMB_ADDR, 1'b1);
    sw(8'h00, 1'b1);
    i_slscs_host.start;
    sw(8'hD3, 1'b1);
    sr(8'h06, 1'b1);
    sr(8'h1C, 1'b1);
    sr(8'h22, 1'b1);
    sr(8'h5A, 1'b0);
    i_slscs_host.stop;
    // Power-down mode with a reserved select code.
    i_freq_select <= 5'h04;
    reset_dut(1'b0);
    i_cpu_power_good_strobe_n <= 1'b0;
    board_low <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk_bit("powerdown", 1'b1, o_powerdown);
    chk("buf off", 32'h00000000, o_buf_enable);
    chk_bit("reserved", 1'b1, o_sel_reserved);
    rd(`SLSCS_OFF_STATUS, 32'h0000040B);
    rd(`SLSCS_OFF_FREQ_A, 32'h00000000);
    wr(`SLSCS_OFF_CTRL, 32'h00000001);
    chk_bit("pin oe_n", 1'b1, o_reset_out_or_powerdown_in_pin_oe_n);
    byte_read(7'h03, 8'hFF);
    tally_and_finish;
  end
endmodule

bind slscs_top slscs_properties i_slscs_properties (
  .i_clk, .i_rst_n, .i_cpu_power_good_strobe_n, .i_serial_clock_line, .o_sel_valid,
  .o_sel_reserved, .o_latched_select, .o_cpu_freq_x10, .o_vco_freq_x10, .o_powerdown,
  .o_buf_enable, .o_serial_data_line_oe_n, .o_reset_out_or_powerdown_in_pin_oe_n
);
